// File: include/utx_regs.vh
// constants for the user table segment transfer command interpreter
// assumes 16-bit command words and a 16-bit word-wide user table
`ifndef UTX_REGS_VH
`define UTX_REGS_VH

// command block layout and fixed header values
`define UTX_BLOCK_WORDS 4'd10
`define UTX_HDR_LEN 16'h0004
`define UTX_MODE_NOWAIT 16'h0000

// memory type codes
`define UTX_MT_DIN 16'h0046
`define UTX_MT_DOUT 16'h0048
`define UTX_MT_REG 16'h0008
`define UTX_MT_AIN 16'h000a
`define UTX_MT_AOUT 16'h000c

// command codes: writes copy host to table, reads copy table to host
`define UTX_CMD_WR1 16'hd001
`define UTX_CMD_WR2 16'hd101
`define UTX_CMD_WR3 16'hd201
`define UTX_CMD_WR4 16'hd301
`define UTX_CMD_RD1 16'hd804
`define UTX_CMD_RD2 16'hd904
`define UTX_CMD_RD3 16'hda04
`define UTX_CMD_RD4 16'hdb04
`define UTX_CMD_PARAM 16'he501

// segment geometry
`define UTX_SEG_BYTES 16'h0800
`define UTX_SEG_WORDS 11'h400
`define UTX_TBL_WORDS 4096
`define UTX_TBL_AW 12

// completion codes reported in the status word
`define UTX_ST_OK 16'h0001
`define UTX_ST_BAD_HDR 16'h0002
`define UTX_ST_PARAM 16'h0003
`define UTX_ST_BAD_CMD 16'h0004
`define UTX_ST_BAD_SIZE 16'h0005
`define UTX_ST_BAD_AREA 16'h0006
`define UTX_ST_BAD_STS 16'h0007

// fifo in the data path
`define UTX_FIFO_W 16
`define UTX_FIFO_D 4
`define UTX_FIFO_AW 2

`endif

// File: rtl/utx_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock; ce low freezes all state
`timescale 1ns/1ps
module utx_fifo #(
  parameter W = 16,
  parameter D = 4,
  parameter AW = 2
) (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;

  always @(posedge mclk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      // depth is a power of two, so pointers wrap naturally
      if (push)
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // utx_fifo

// File: rtl/utx_core.v
// user table segment transfer: takes a ten-word command block,
// checks it, moves one segment between host word memory and the table,
// then reports a completion code for the status word
// assumes the host logic runs on mclk; host memory port is req/ack,
// host read data come back later on hm_rvalid
// How it works
// R1: first block word must be 4, otherwise a header error is reported
// R2: second word is zero from the host; nonzero is also rejected
// R3: third word names the status area: 70, 72, 8, 10 or 12
// R4: discrete status area means sixteen consecutive bits form the status word
// R5: fourth word is the zero-based status offset, passed out unchanged
// R6: fifth and sixth words are read but ignored
// R7: seventh word must be one of the eight command codes
// R8: write codes d001..d301 copy host data into segments 1 to 4
// R9: read codes d804..db04 copy segments 1 to 4 into host memory
// R10: eighth word must equal 2048 bytes; every transfer moves exactly that
// R11: ninth word data area must be 8, 10 or 12; discrete refused
// R12: tenth word is the zero-based host data start offset
// R13: transfer walks 1024 contiguous host words from the start offset
// R14: words seven to ten form the data header held for the transfer
// R15: parameter load code is refused, never used as a table load
// R16: host scan pacing is the host's business; no timing assumed here
// R17: host avoids conflicting memory users while a transfer runs
// R18: 8192-byte table is four 2048-byte segments, selected by code
// R19: host writes the reported outcome into its status word
// R20: bad code, size or data area: no transfer, error status reported
`timescale 1ns/1ps
`include "utx_regs.vh"
module utx_core (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire cmd_valid,
  input wire [15:0] cmd_word,
  output reg cmd_ready_r,
  output reg hm_req_r,
  output reg hm_we_r,
  output reg [15:0] hm_area_r,
  output reg [15:0] hm_addr_r,
  output reg [15:0] hm_wdata_r,
  input wire hm_ack,
  input wire hm_rvalid,
  input wire [15:0] hm_rdata,
  output reg sts_valid_r,
  output reg [15:0] sts_area_r,
  output reg [15:0] sts_offset_r,
  output reg [15:0] sts_code_r,
  output reg sts_discrete_r,
  output reg busy_r
);
  localparam S_HDR = 5'b00001;
  localparam S_CHK = 5'b00010;
  localparam S_WR = 5'b00100;
  localparam S_RD = 5'b01000;
  localparam S_FIN = 5'b10000;

  reg [4:0] st_r;
  reg [3:0] widx_r;
  reg [15:0] hlen_r;
  reg [15:0] mode_r;
  reg [15:0] sarea_r;
  reg [15:0] soff_r;
  reg [15:0] code_r;
  reg [15:0] size_r;
  reg [15:0] darea_r;
  reg [15:0] doff_r;
  reg [1:0] seg_r;
  reg [10:0] icnt_r;
  reg [10:0] dcnt_r;
  reg hm_pend_r;
  reg tr_pend_r;
  reg [15:0] res_r;
  reg [15:0] tbl_mem [0:`UTX_TBL_WORDS-1];
  reg [15:0] tbl_q_r;
  wire tbl_rd;
  wire tbl_wr;
  wire [3:0] dec;
  wire f_in_valid;
  wire [15:0] f_in_data;
  wire f_in_ready;
  wire f_out_valid;
  wire [15:0] f_out_data;
  wire f_out_ready;

  // bit3 valid, bit2 table-to-host, bits 1:0 segment
  function [3:0] dec_cmd;
    input [15:0] c;
    begin
      case (c)
        `UTX_CMD_WR1: dec_cmd = 4'h8;
        `UTX_CMD_WR2: dec_cmd = 4'h9;
        `UTX_CMD_WR3: dec_cmd = 4'ha;
        `UTX_CMD_WR4: dec_cmd = 4'hb;
        `UTX_CMD_RD1: dec_cmd = 4'hc;
        `UTX_CMD_RD2: dec_cmd = 4'hd;
        `UTX_CMD_RD3: dec_cmd = 4'he;
        `UTX_CMD_RD4: dec_cmd = 4'hf;
        default: dec_cmd = 4'h0;
      endcase
    end
  endfunction

  function word_area;
    input [15:0] a;
    begin
      word_area = (a == `UTX_MT_REG) | (a == `UTX_MT_AIN) | (a == `UTX_MT_AOUT);
    end
  endfunction

  function disc_area;
    input [15:0] a;
    begin
      disc_area = (a == `UTX_MT_DIN) | (a == `UTX_MT_DOUT);
    end
  endfunction

  // host address wraps at 16 bits, like the offset word itself
  function [15:0] add_off;
    input [15:0] base;
    input [10:0] idx;
    begin
      add_off = base + {5'h00, idx};
    end
  endfunction

  assign dec = dec_cmd(code_r);

  // data path fifo: filled by host reads or table reads, drained the other way
  assign f_in_valid = (st_r == S_WR) ? (hm_pend_r & hm_rvalid) : ((st_r == S_RD) & tr_pend_r);
  assign f_in_data = (st_r == S_WR) ? hm_rdata : tbl_q_r;
  assign f_out_ready = (st_r == S_WR) | ((st_r == S_RD) & ~hm_req_r);

  utx_fifo #(
    .W(`UTX_FIFO_W),
    .D(`UTX_FIFO_D),
    .AW(`UTX_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_out_ready)
  );

  // table: segment picks the top two address bits [R18]
  assign tbl_wr = ce & (st_r == S_WR) & f_out_valid;
  assign tbl_rd = ce & (st_r == S_RD) & ~tr_pend_r & f_in_ready & (icnt_r != `UTX_SEG_WORDS);

  always @(posedge mclk)
  begin
    if (tbl_wr)
      tbl_mem[{seg_r, dcnt_r[9:0]}] <= f_out_data; // [R8]
    if (tbl_rd)
      tbl_q_r <= tbl_mem[{seg_r, icnt_r[9:0]}]; // [R9]
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= S_HDR;
      widx_r <= 4'h0;
      hlen_r <= 16'h0000;
      mode_r <= 16'h0000;
      sarea_r <= 16'h0000;
      soff_r <= 16'h0000;
      code_r <= 16'h0000;
      size_r <= 16'h0000;
      darea_r <= 16'h0000;
      doff_r <= 16'h0000;
      seg_r <= 2'h0;
      icnt_r <= 11'h000;
      dcnt_r <= 11'h000;
      hm_pend_r <= 1'b0;
      tr_pend_r <= 1'b0;
      res_r <= 16'h0000;
      cmd_ready_r <= 1'b1;
      hm_req_r <= 1'b0;
      hm_we_r <= 1'b0;
      hm_area_r <= 16'h0000;
      hm_addr_r <= 16'h0000;
      hm_wdata_r <= 16'h0000;
      sts_valid_r <= 1'b0;
      sts_area_r <= 16'h0000;
      sts_offset_r <= 16'h0000;
      sts_code_r <= 16'h0000;
      sts_discrete_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else if (ce)
    begin
      sts_valid_r <= 1'b0;
      case (st_r)
        S_HDR:
        begin
          if (cmd_valid & cmd_ready_r)
          begin
            busy_r <= 1'b1;
            case (widx_r)
              4'd0: hlen_r <= cmd_word;
              4'd1: mode_r <= cmd_word;
              4'd2: sarea_r <= cmd_word;
              4'd3: soff_r <= cmd_word; // [R5]
              4'd6: code_r <= cmd_word; // [R14]
              4'd7: size_r <= cmd_word;
              4'd8: darea_r <= cmd_word;
              4'd9: doff_r <= cmd_word; // [R12]
              default: ; // idle timeout and max time are not kept [R6]
            endcase
            if (widx_r == `UTX_BLOCK_WORDS - 4'd1)
            begin
              widx_r <= 4'h0;
              cmd_ready_r <= 1'b0;
              st_r <= S_CHK;
            end
            else
              widx_r <= widx_r + 4'h1;
          end
        end
        S_CHK:
        begin
          icnt_r <= 11'h000;
          dcnt_r <= 11'h000;
          seg_r <= dec[1:0];
          hm_area_r <= darea_r;
          // any failure skips the transfer entirely [R20]
          if (hlen_r != `UTX_HDR_LEN || mode_r != `UTX_MODE_NOWAIT)
          begin
            res_r <= `UTX_ST_BAD_HDR; // [R1] [R2]
            st_r <= S_FIN;
          end
          else if (code_r == `UTX_CMD_PARAM)
          begin
            res_r <= `UTX_ST_PARAM; // [R15]
            st_r <= S_FIN;
          end
          else if (!dec[3])
          begin
            res_r <= `UTX_ST_BAD_CMD; // [R7]
            st_r <= S_FIN;
          end
          else if (size_r != `UTX_SEG_BYTES)
          begin
            res_r <= `UTX_ST_BAD_SIZE; // [R10]
            st_r <= S_FIN;
          end
          else if (!word_area(darea_r))
          begin
            res_r <= `UTX_ST_BAD_AREA; // [R11]
            st_r <= S_FIN;
          end
          else if (!word_area(sarea_r) && !disc_area(sarea_r))
          begin
            res_r <= `UTX_ST_BAD_STS; // [R3]
            st_r <= S_FIN;
          end
          else
          begin
            res_r <= `UTX_ST_OK;
            st_r <= dec[2] ? S_RD : S_WR; // [R8] [R9]
          end
        end
        S_WR:
        begin
          // one host read in flight keeps fifo space guaranteed on return
          if (!hm_req_r && !hm_pend_r && f_in_ready && icnt_r != `UTX_SEG_WORDS)
          begin
            hm_req_r <= 1'b1;
            hm_we_r <= 1'b0;
            hm_addr_r <= add_off(doff_r, icnt_r); // [R13]
          end
          if (hm_req_r && hm_ack)
          begin
            hm_req_r <= 1'b0;
            hm_pend_r <= 1'b1;
            icnt_r <= icnt_r + 11'h001;
          end
          if (hm_pend_r && hm_rvalid)
            hm_pend_r <= 1'b0;
          if (f_out_valid)
          begin
            dcnt_r <= dcnt_r + 11'h001;
            if (dcnt_r == `UTX_SEG_WORDS - 11'h001)
              st_r <= S_FIN; // [R10]
          end
        end
        S_RD:
        begin
          if (tbl_rd)
          begin
            tr_pend_r <= 1'b1;
            icnt_r <= icnt_r + 11'h001;
          end
          else
            tr_pend_r <= 1'b0;
          // host write requests stall on ack, which backs up the fifo
          if (!hm_req_r && f_out_valid)
          begin
            hm_req_r <= 1'b1;
            hm_we_r <= 1'b1;
            hm_addr_r <= add_off(doff_r, dcnt_r); // [R13]
            hm_wdata_r <= f_out_data;
          end
          if (hm_req_r && hm_ack)
          begin
            hm_req_r <= 1'b0;
            dcnt_r <= dcnt_r + 11'h001;
            if (dcnt_r == `UTX_SEG_WORDS - 11'h001)
              st_r <= S_FIN; // [R10]
          end
        end
        S_FIN:
        begin
          hm_we_r <= 1'b0;
          sts_valid_r <= 1'b1;
          sts_area_r <= sarea_r;
          sts_offset_r <= soff_r;
          sts_code_r <= res_r;
          sts_discrete_r <= disc_area(sarea_r); // [R4]
          busy_r <= 1'b0;
          cmd_ready_r <= 1'b1;
          st_r <= S_HDR;
        end
        default:
        begin
          st_r <= S_HDR;
          cmd_ready_r <= 1'b1;
        end
      endcase
    end
  end
endmodule // utx_core

// File: tb/utx_host_model.sv
// host word memory model facing the core's memory port
// assumes one clock; ack is a one-cycle pulse, read data follow a cycle later
`timescale 1ns/1ps
module utx_host_model (
  input wire mclk,
  input wire rst_b,
  input wire slow,
  input wire hm_req_r,
  input wire hm_we_r,
  input wire [15:0] hm_addr_r,
  input wire [15:0] hm_wdata_r,
  output reg hm_ack,
  output reg hm_rvalid,
  output reg [15:0] hm_rdata
);
  reg [15:0] mem [0:2047];
  reg ph_r;
  integer i;
  initial
  begin
    for (i = 0; i < 2048; i = i + 1)
      mem[i] = i[15:0] * 16'h0107 + 16'h0033;
  end
  // slow mode acks every other cycle only
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hm_ack <= 1'b0;
      hm_rvalid <= 1'b0;
      hm_rdata <= 16'h0;
      ph_r <= 1'b0;
    end
    else
    begin
      ph_r <= ~ph_r;
      hm_rvalid <= 1'b0;
      // idle bus flips so stale data never pass as fresh
      hm_rdata <= ~hm_rdata;
      hm_ack <= hm_req_r & ~hm_ack & (~slow | ph_r);
      if (hm_req_r & hm_ack)
      begin
        if (hm_we_r)
          mem[hm_addr_r[10:0]] <= hm_wdata_r;
        else
        begin
          hm_rvalid <= 1'b1;
          hm_rdata <= mem[hm_addr_r[10:0]];
        end
      end
    end
  end
endmodule // utx_host_model

// File: tb/utx_core_props.sv
// checker for the segment transfer core, ports only
// assumes one clock domain and ce held high
`timescale 1ns/1ps
`include "utx_regs.vh"
module utx_core_props (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire cmd_valid,
  input wire [15:0] cmd_word,
  input wire cmd_ready_r,
  input wire hm_req_r,
  input wire hm_we_r,
  input wire [15:0] hm_area_r,
  input wire [15:0] hm_addr_r,
  input wire hm_ack,
  input wire sts_valid_r,
  input wire [15:0] sts_area_r,
  input wire [15:0] sts_code_r,
  input wire sts_discrete_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire take = ce & cmd_valid & cmd_ready_r;
  wire acc = ce & hm_req_r & hm_ack;
  reg [3:0] nw_r;
  reg [10:0] na_r;
  reg [15:0] la_r, doff_r, w1_r, cm_r;
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nw_r <= 4'h0;
      na_r <= 11'h0;
    end
    else
    begin
      if (take)
        nw_r <= (nw_r == 4'h9) ? 4'h0 : nw_r + 4'h1;
      if (take && nw_r == 4'h0)
        na_r <= 11'h0;
      else if (acc)
        na_r <= na_r + 11'h1;
    end
  end
  always @(posedge mclk)
  begin
    if (acc)
      la_r <= hm_addr_r;
    if (take && nw_r == 4'h0)
      w1_r <= cmd_word;
    if (take && nw_r == 4'h6)
      cm_r <= cmd_word;
    if (take && nw_r == 4'h9)
      doff_r <= cmd_word;
  end
  property p_ready_drop;
    take && nw_r == 4'h9 |=> !cmd_ready_r;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready after last word");
  property p_req_hold;
    hm_req_r && !hm_ack |=> hm_req_r && $stable(hm_addr_r) && $stable(hm_we_r);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request not held");
  property p_addr_step;
    acc && na_r != 11'h0 |-> hm_addr_r == la_r + 16'h1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not contiguous");
  property p_first_addr;
    acc && na_r == 11'h0 |-> hm_addr_r == doff_r;
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("bad start offset");
  property p_area;
    hm_req_r |-> hm_area_r inside {`UTX_MT_REG, `UTX_MT_AIN, `UTX_MT_AOUT};
  endproperty
  a_area: assert property (p_area) else $error("bad data area used");
  property p_dir;
    acc |-> hm_we_r == cm_r[11];
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_count;
    sts_valid_r |-> na_r == ((sts_code_r == `UTX_ST_OK) ? 11'h400 : 11'h0);
  endproperty
  a_count: assert property (p_count) else $error("word count wrong");
  property p_hdr;
    sts_valid_r && w1_r != `UTX_HDR_LEN |-> sts_code_r == `UTX_ST_BAD_HDR;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header length accepted");
  property p_disc;
    sts_valid_r |-> sts_discrete_r == (sts_area_r inside {`UTX_MT_DIN, `UTX_MT_DOUT});
  endproperty
  a_disc: assert property (p_disc) else $error("discrete flag wrong");
  c_ok: cover property (sts_valid_r && sts_code_r == `UTX_ST_OK);
  c_err: cover property (sts_valid_r && sts_code_r == `UTX_ST_BAD_CMD);
  c_wait: cover property ((hm_req_r && !hm_ack) [*2]);
endmodule // utx_core_props
bind utx_core utx_core_props u_utx_core_props (.mclk(mclk), .rst_b(rst_b), .ce(ce),
  .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready_r(cmd_ready_r),
  .hm_req_r(hm_req_r), .hm_we_r(hm_we_r), .hm_area_r(hm_area_r), .hm_addr_r(hm_addr_r),
  .hm_ack(hm_ack), .sts_valid_r(sts_valid_r), .sts_area_r(sts_area_r),
  .sts_code_r(sts_code_r), .sts_discrete_r(sts_discrete_r));

// File: tb/testbench.sv
// self-checking bench: command blocks in, host memory model on the far side
// assumes ce stays high; host memory starts with a known pattern
`timescale 1ns/1ps
`include "utx_regs.vh"
module testbench;
  reg mclk, rst_b, ce, cmd_valid, slow;
  reg [15:0] cmd_word;
  wire cmd_ready_r, hm_req_r, hm_we_r, hm_ack, hm_rvalid, sts_valid_r, sts_discrete_r;
  wire busy_r;
  wire [15:0] hm_area_r, hm_addr_r, hm_wdata_r, hm_rdata, sts_area_r, sts_offset_r;
  wire [15:0] sts_code_r;
  integer mismatches, n_compared, k, i;
  reg [15:0] cm;
  // host-side copy of the reported outcome, as the host keeps it
  reg [15:0] status_word;
  utx_core u_utx_core (.mclk(mclk), .rst_b(rst_b), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_ready_r(cmd_ready_r), .hm_req_r(hm_req_r),
    .hm_we_r(hm_we_r), .hm_area_r(hm_area_r), .hm_addr_r(hm_addr_r),
    .hm_wdata_r(hm_wdata_r), .hm_ack(hm_ack), .hm_rvalid(hm_rvalid),
    .hm_rdata(hm_rdata), .sts_valid_r(sts_valid_r), .sts_area_r(sts_area_r),
    .sts_offset_r(sts_offset_r), .sts_code_r(sts_code_r),
    .sts_discrete_r(sts_discrete_r), .busy_r(busy_r));
  utx_host_model u_utx_host_model (.mclk(mclk), .rst_b(rst_b), .slow(slow),
    .hm_req_r(hm_req_r), .hm_we_r(hm_we_r), .hm_addr_r(hm_addr_r),
    .hm_wdata_r(hm_wdata_r), .hm_ack(hm_ack), .hm_rvalid(hm_rvalid),
    .hm_rdata(hm_rdata));
  function [15:0] pat(input [15:0] a);
    pat = a * 16'h0107 + 16'h0033;
  endfunction
  task end_of_test;
  begin
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task put(input [15:0] x);
  begin
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_word <= x;
  end
  endtask
  // words five and six always zero
  task run(input [15:0] w1, w2, sa, c, sz, da, dof, ex);
    integer j;
  begin
    put(w1);
    put(w2);
    put(sa);
    put(dof + 16'h3);
    put(16'h0);
    put(16'h0);
    put(c);
    put(sz);
    put(da);
    put(dof);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    chk({15'h0, busy_r}, 16'h1);
    for (j = 0; j < 20000 && sts_valid_r !== 1'b1; j = j + 1)
      @(negedge mclk);
    if (j == 20000)
    begin
      mismatches = mismatches + 1;
      end_of_test;
    end
    chk(sts_code_r, ex);
    chk(sts_area_r, sa);
    chk(sts_offset_r, dof + 16'h3);
    chk({15'h0, sts_discrete_r}, {15'h0, sa == 16'h46 || sa == 16'h48});
    chk({15'h0, busy_r}, 16'h0);
    chk({15'h0, cmd_ready_r}, 16'h1);
    status_word = sts_code_r;
    chk(status_word, ex);
  end
  endtask
  task t_err;
  begin
    run(16'h5, 16'h0, 16'h8, 16'hd001, 16'h800, 16'h8, 16'h0, 16'h2);
    run(16'h4, 16'h1, 16'hc, 16'hd001, 16'h800, 16'h8, 16'h0, 16'h2);
    run(16'h4, 16'h0, 16'h8, 16'he501, 16'h800, 16'h8, 16'h0, 16'h3);
    run(16'h4, 16'h0, 16'h8, 16'hd002, 16'h800, 16'h8, 16'h0, 16'h4);
    run(16'h4, 16'h0, 16'h8, 16'hd001, 16'h7fe, 16'h8, 16'h0, 16'h5);
    run(16'h4, 16'h0, 16'h8, 16'hd804, 16'h800, 16'h46, 16'h0, 16'h6);
    run(16'h4, 16'h0, 16'h9, 16'hd001, 16'h800, 16'h8, 16'h0, 16'h7);
    $display("error blocks done");
  end
  endtask
  // each segment gets its own source offset, so a mixed-up segment shows
  task t_write;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      cm = 16'hd001 + {k[7:0], 8'h00};
      case (k)
        0: run(16'h4, 16'h0, 16'h46, cm, 16'h800, 16'h8, 16'h0, 16'h1);
        1: run(16'h4, 16'h0, 16'h48, cm, 16'h800, 16'ha, 16'h8, 16'h1);
        2: run(16'h4, 16'h0, 16'h8, cm, 16'h800, 16'hc, 16'h10, 16'h1);
        default: run(16'h4, 16'h0, 16'ha, cm, 16'h800, 16'h8, 16'h18, 16'h1);
      endcase
    end
    $display("segment writes done");
  end
  endtask
  task t_read;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      slow <= k[0];
      cm = 16'hd804 + {k[7:0], 8'h00};
      run(16'h4, 16'h0, 16'hc, cm, 16'h800, 16'ha, 16'h400, 16'h1);
      for (i = 0; i < 1024; i = i + 1)
        chk(u_utx_host_model.mem[1024 + i], pat(k * 8 + i));
    end
    $display("segment reads done");
  end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_word = 16'h0;
    slow = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_err;
    t_write;
    t_read;
    end_of_test;
  end
endmodule // testbench
